//--- hdl/srrs_pkg.sv
// package: register map, command codes, flag layout and reset values of the host command block
package srrs_pkg;

   // ----------------------------------------------------------------
   // register map (word addresses on the host port)
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_DEVICE_IDENT        = 6'h00;
   localparam logic [5:0] ADDR_HOST_PORT_CONTROL   = 6'h01;
   localparam logic [5:0] ADDR_LINK_CONTROL        = 6'h02;
   localparam logic [5:0] ADDR_TRANSMIT_QUEUE_LVL  = 6'h03;
   localparam logic [5:0] ADDR_RECEIVE_QUEUE_LVL   = 6'h04;
   localparam logic [5:0] ADDR_DEVICE_CONTROL      = 6'h05;
   localparam logic [5:0] ADDR_DIAGNOSTIC_MASK     = 6'h06;
   localparam logic [5:0] ADDR_GLOBAL_STATUS       = 6'h07;
   localparam logic [5:0] ADDR_INTERFACE_DETAIL    = 6'h08;
   localparam logic [5:0] ADDR_TRANSMIT_QUEUE_STAT = 6'h09;
   localparam logic [5:0] ADDR_RECEIVE_QUEUE_STAT  = 6'h0a;

   // ----------------------------------------------------------------
   // values after reset of the writable registers (index 1..6)
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_HOST_PORT_CONTROL  = 16'h00a0;
   localparam logic [15:0] RST_LINK_CONTROL       = 16'h0000;
   localparam logic [15:0] RST_TRANSMIT_QUEUE_LVL = 16'h01ff;
   localparam logic [15:0] RST_RECEIVE_QUEUE_LVL  = 16'h0000;
   localparam logic [15:0] RST_DEVICE_CONTROL     = 16'h0000;
   localparam logic [15:0] RST_DIAGNOSTIC_MASK    = 16'h0000;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CRC_ALG_BIT  = 2;    // host_crc_algorithm_select in host_port_control
   localparam int SDO_DIS_BIT  = 1;    // host_port_control: output never driven
   localparam int FLAG_POR     = 0;    // global_status: power-on flag
   localparam int FLAG_ERR     = 1;    // global_status: global error flag
   localparam int FLAG_HCRC    = 2;    // global_status: host crc error
   localparam int FLAG_SRSTF   = 3;    // global_status: soft_reset_fail_flag
   localparam logic [15:0] RST_GLOBAL_STATUS = 16'h0003;

   // ----------------------------------------------------------------
   // command word layout and codes
   // ----------------------------------------------------------------
   localparam int          OP_MSB       = 15;
   localparam int          OP_LSB       = 12;
   localparam int          ADDR_MSB     = 11;
   localparam int          ADDR_LSB     = 6;
   localparam int          CNT_MSB      = 5;
   localparam logic [3:0]  OP_REG_READ  = 4'hd;
   localparam logic [15:0] CMD_SOFT_RST = 16'he1e1;
   localparam logic [15:0] CRC_POLY     = 16'h1021;
   localparam logic [15:0] CRC_INIT_A0  = 16'hffff;   // first algorithm
   localparam logic [15:0] CRC_INIT_A1  = 16'h0000;   // alternative algorithm
   localparam logic [15:0] IDLE_WORD    = 16'hffff;
   localparam logic [3:0]  LAST_BIT     = 4'hf;

endpackage

//--- hdl/srrs_cmd.sv
// host serial port command block: unchecked register read, checked soft reset, register map
`timescale 1ns/1ps
// Function
// - read returns registers from command start address
// - unchecked read replies even on crc error
// - bad read crc sets flag, pulls fault
// - soft reset defaults registers, resyncs link
// - soft reset needs good crc, idle link
// - soft reset word e1e1 plus algorithm crc
// - soft reset clears flags, sets power-on, error
// - soft reset makes receive queue inaccessible
// - soft reset clears computed link crc values
// - soft reset leaves safe hold state
// - refused soft reset sets failure flag
// - eleven sixteen-bit registers at 0x0..0xa
// - identification register read-only fixed code
// - control bit 2 selects crc algorithm
module srrs_cmd
   import srrs_pkg::*;
#(
   parameter logic [15:0] IDENT_CODE = 16'h5a3c   // arbitrary neutral value
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   output logic             sdo_o,
   output logic             sdo_oe,
   output logic             fault_n_o,
   output logic             fault_n_oe,
   input  wire logic        link_busy_i,
   input  wire logic        safe_hold_enter_i,
   output logic             safe_hold_o,
   output logic             link_resync_o,
   output logic             rx_queue_flush_o,
   output logic             link_crc_clear_o,
   input  wire logic        reg_wr_en_i,
   input  wire logic [5:0]  reg_wr_addr_i,
   input  wire logic [15:0] reg_wr_data_i,
   input  wire logic [15:0] iface_status_i,
   input  wire logic [15:0] txq_status_i,
   input  wire logic [15:0] rxq_status_i
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_CMD, ST_CRC, ST_REPLY, ST_DONE} srrs_phase_t;

   typedef struct packed {
      logic             sclk_s1;
      logic             sclk_s2;
      logic             sclk_d;
      logic             cs_s1;
      logic             cs_s2;
      logic             sdi_s1;
      logic             sdi_s2;
      srrs_phase_t      st;
      logic [3:0]       bit_cnt;
      logic [15:0]      rx_shift;
      logic [15:0]      cmd_word;
      logic [15:0]      tx_shift;
      logic [15:0]      crc_out;
      logic [5:0]       rd_addr;
      logic [6:0]       words_left;
      logic [6:1][15:0] regs;
      logic [15:0]      status;
      logic             safe_hold;
      logic             resync;
      logic             flush;
      logic             crc_clr;
      logic             sdo;
      logic             sdo_oe;
      logic             fault_oe;
   } srrs_state_t;

   srrs_state_t q, d;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // one sixteen-bit word through the crc, msb first
   function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [15:0] w);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         r = (r[15] ^ w[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
      end
      return r;
   endfunction

   // start value of the running crc for the chosen algorithm
   function automatic logic [15:0] crc_init(input logic alg);
      return alg ? CRC_INIT_A1 : CRC_INIT_A0;
   endfunction

   // register map decode; unlisted addresses read as zero
   function automatic logic [15:0] read_reg(input logic [5:0] a, input logic [6:1][15:0] r,
                                            input logic [15:0] st);
      logic [15:0] v;
      v = 16'h0000;
      case (a)
         ADDR_DEVICE_IDENT:        v = IDENT_CODE;
         ADDR_HOST_PORT_CONTROL:   v = r[1];
         ADDR_LINK_CONTROL:        v = r[2];
         ADDR_TRANSMIT_QUEUE_LVL:  v = r[3];
         ADDR_RECEIVE_QUEUE_LVL:   v = r[4];
         ADDR_DEVICE_CONTROL:      v = r[5];
         ADDR_DIAGNOSTIC_MASK:     v = r[6];
         ADDR_GLOBAL_STATUS:       v = st;
         ADDR_INTERFACE_DETAIL:    v = iface_status_i;
         ADDR_TRANSMIT_QUEUE_STAT: v = txq_status_i;
         ADDR_RECEIVE_QUEUE_STAT:  v = rxq_status_i;
         default:                  v = 16'h0000;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // decode of the synchronised serial pins and the command word
   // ----------------------------------------------------------------
   logic        cs_act;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        word_done;
   logic [15:0] rx_word;
   logic        alg;
   logic        crc_ok;
   logic        is_srst;
   logic        is_read;
   logic        crc_end;
   logic        srst_go;
   logic        srst_bad;
   logic        rd_bad;

   // edges are taken from the second stage only, never the first
   assign cs_act    = ~q.cs_s2;
   assign sclk_rise = q.sclk_s2 & ~q.sclk_d;
   assign sclk_fall = ~q.sclk_s2 & q.sclk_d;
   assign word_done = cs_act & sclk_rise & (q.bit_cnt == LAST_BIT);
   assign rx_word   = {q.rx_shift[14:0], q.sdi_s2};
   assign alg       = q.regs[1][CRC_ALG_BIT];
   assign crc_ok    = (rx_word == crc16_word(crc_init(alg), q.cmd_word));
   assign is_srst   = (q.cmd_word == CMD_SOFT_RST);
   assign is_read   = (q.cmd_word[OP_MSB:OP_LSB] == OP_REG_READ);
   assign crc_end   = word_done & (q.st == ST_CRC);
   assign srst_go   = crc_end & is_srst & crc_ok & ~link_busy_i;
   assign srst_bad  = crc_end & is_srst & ~(crc_ok & ~link_busy_i);
   assign rd_bad    = crc_end & is_read & ~crc_ok;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] w;
      logic [15:0] set_flags;
      logic        load;
      w         = 16'h0000;
      set_flags = 16'h0000;
      load      = 1'b0;
      d         = q;
      // two-flop synchronisers for the pins from the host
      d.sclk_s1 = sclk;
      d.sclk_s2 = q.sclk_s1;
      d.sclk_d  = q.sclk_s2;
      d.cs_s1   = cs_n;
      d.cs_s2   = q.cs_s1;
      d.sdi_s1  = sdi;
      d.sdi_s2  = q.sdi_s1;
      d.resync  = 1'b0;
      d.flush   = 1'b0;
      d.crc_clr = 1'b0;

      // side writes from the other command paths; status is write-one-to-clear
      if (reg_wr_en_i) begin
         if (reg_wr_addr_i >= ADDR_HOST_PORT_CONTROL && reg_wr_addr_i <= ADDR_DIAGNOSTIC_MASK) begin
            d.regs[reg_wr_addr_i[2:0]] = reg_wr_data_i;   // device_ident is never written
         end else if (reg_wr_addr_i == ADDR_GLOBAL_STATUS) begin
            d.status = q.status & ~reg_wr_data_i;
         end
      end

      if (!cs_act) begin
         // frame ended: drop any partial word and stop replying
         d.st       = ST_CMD;
         d.bit_cnt  = 4'h0;
         d.tx_shift = IDLE_WORD;
      end else begin
         if (sclk_rise) begin
            d.rx_shift = rx_word;
            d.bit_cnt  = q.bit_cnt + 4'h1;
         end
         // shift out on the falling edge, but not the one right after a load
         if (sclk_fall && q.bit_cnt != 4'h0) begin
            d.tx_shift = {q.tx_shift[14:0], 1'b1};
         end
         if (word_done) begin
            case (q.st)
               ST_CMD: begin
                  d.cmd_word = rx_word;
                  d.st       = ST_CRC;
               end
               ST_CRC: begin
                  d.crc_out = crc_init(alg);
                  if (is_read) begin
                     // reply goes out whatever the crc said
                     d.rd_addr    = q.cmd_word[ADDR_MSB:ADDR_LSB];
                     d.words_left = {1'b0, q.cmd_word[CNT_MSB:0]} + 7'h01;
                     d.st         = ST_REPLY;
                     load         = 1'b1;
                     if (!crc_ok) begin
                        set_flags[FLAG_HCRC] = 1'b1;
                     end
                  end else if (is_srst) begin
                     d.rd_addr    = ADDR_GLOBAL_STATUS;
                     d.words_left = 7'h01;
                     d.st         = ST_REPLY;
                     load         = 1'b1;
                     if (srst_go) begin
                        d.regs[1]   = RST_HOST_PORT_CONTROL;
                        d.regs[2]   = RST_LINK_CONTROL;
                        d.regs[3]   = RST_TRANSMIT_QUEUE_LVL;
                        d.regs[4]   = RST_RECEIVE_QUEUE_LVL;
                        d.regs[5]   = RST_DEVICE_CONTROL;
                        d.regs[6]   = RST_DIAGNOSTIC_MASK;
                        d.status    = RST_GLOBAL_STATUS;
                        d.safe_hold = 1'b0;
                        d.resync    = 1'b1;
                        d.flush     = 1'b1;
                        d.crc_clr   = 1'b1;
                        d.crc_out   = crc_init(RST_HOST_PORT_CONTROL[CRC_ALG_BIT]);
                     end else begin
                        set_flags[FLAG_SRSTF] = 1'b1;
                     end
                  end else begin
                     // other commands belong to other paths; stay quiet here
                     d.st       = ST_DONE;
                     d.tx_shift = IDLE_WORD;
                  end
               end
               ST_REPLY: load = 1'b1;
               ST_DONE:  d.tx_shift = IDLE_WORD;
               default:  d.st = ST_CMD;
            endcase
         end
      end

      // events win over a clear; merged before the reply load so a status reply shows this command's flags
      if (set_flags != 16'h0000) begin
         set_flags[FLAG_ERR] = 1'b1;
      end
      d.status = d.status | set_flags;

      // next reply word: a register, then the crc over all of them
      if (load) begin
         if (d.words_left != 7'h00) begin
            w            = read_reg(d.rd_addr, d.regs, d.status);
            d.tx_shift   = w;
            d.crc_out    = crc16_word(d.crc_out, w);
            d.rd_addr    = d.rd_addr + 6'h01;
            d.words_left = d.words_left - 7'h01;
         end else begin
            d.tx_shift = d.crc_out;
            d.st       = ST_DONE;
         end
      end

      if (safe_hold_enter_i && !srst_go) begin
         d.safe_hold = 1'b1;
      end

      // pins, all registered
      d.sdo      = d.tx_shift[15];
      d.sdo_oe   = ~d.cs_s2 & ~d.regs[1][SDO_DIS_BIT];
      d.fault_oe = |(d.status & ~d.regs[6]);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q            <= '0;
         q.sclk_s1    <= 1'b0;
         q.cs_s1      <= 1'b1;
         q.cs_s2      <= 1'b1;
         q.st         <= ST_CMD;
         q.tx_shift   <= IDLE_WORD;
         q.crc_out    <= CRC_INIT_A0;
         q.regs[1]    <= RST_HOST_PORT_CONTROL;
         q.regs[2]    <= RST_LINK_CONTROL;
         q.regs[3]    <= RST_TRANSMIT_QUEUE_LVL;
         q.regs[4]    <= RST_RECEIVE_QUEUE_LVL;
         q.regs[5]    <= RST_DEVICE_CONTROL;
         q.regs[6]    <= RST_DIAGNOSTIC_MASK;
         q.status     <= RST_GLOBAL_STATUS;
         q.sdo        <= 1'b1;
         q.fault_oe   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign sdo_o            = q.sdo;
   assign sdo_oe           = q.sdo_oe;
   assign fault_n_o        = 1'b0;   // open drain: only ever pulls low
   assign fault_n_oe       = q.fault_oe;
   assign safe_hold_o      = q.safe_hold;
   assign link_resync_o    = q.resync;
   assign rx_queue_flush_o = q.flush;
   assign link_crc_clear_o = q.crc_clr;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence srst_accept_s;
      srst_go;
   endsequence

   sequence srst_effects_s;
      link_resync_o && rx_queue_flush_o && link_crc_clear_o && !safe_hold_o &&
      q.status == RST_GLOBAL_STATUS && q.regs[1] == RST_HOST_PORT_CONTROL;
   endsequence

   srst_effect_a: assert property (@(posedge clk) disable iff (sys_rst)
      srst_accept_s |=> srst_effects_s)
      else $error("soft reset did not restore defaults");

   srst_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      link_resync_o |-> $past(crc_ok) && !$past(link_busy_i) && $past(is_srst))
      else $error("soft reset ran without good crc or with busy link");

   srst_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
      srst_bad |=> q.status[FLAG_SRSTF] && q.status[FLAG_ERR] && !link_resync_o)
      else $error("refused soft reset not recorded");

   flush_tie_a: assert property (@(posedge clk) disable iff (sys_rst)
      rx_queue_flush_o == link_resync_o && link_crc_clear_o == link_resync_o)
      else $error("soft reset pulses disagree");

   rd_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      rd_bad && !q.regs[6][FLAG_HCRC] && !(reg_wr_en_i && reg_wr_addr_i == ADDR_DIAGNOSTIC_MASK)
      |=> q.status[FLAG_HCRC] ##1 fault_n_oe)
      else $error("bad read crc did not raise the fault");

   rd_reply_a: assert property (@(posedge clk) disable iff (sys_rst)
      crc_end && is_read |=> q.st == ST_REPLY &&
      q.rd_addr == $past(q.cmd_word[ADDR_MSB:ADDR_LSB]) + 6'h01)
      else $error("read did not start at the command address");

   ident_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
      crc_end && is_read && q.cmd_word[ADDR_MSB:ADDR_LSB] == ADDR_DEVICE_IDENT |=> q.tx_shift == IDENT_CODE)
      else $error("identification word wrong");

   srst_reply_a: assert property (@(posedge clk) disable iff (sys_rst)
      crc_end && is_srst |=> q.tx_shift == q.status && q.words_left == 7'h00)
      else $error("soft reset reply is not the status word");

   alg_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
      crc_end && is_srst && !link_busy_i && rx_word == (alg ? 16'hce8c : 16'hd383) |-> srst_go)
      else $error("soft reset crc constant not accepted");

endmodule

//--- bench/srrs_host_model.sv
// host serial controller model: mode 0 frames, msb first, eight system clocks a bit
`timescale 1ns/1ps
module srrs_host_model
   import srrs_pkg::*;
(
   input  wire logic clk,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   // ----------------------------------------------------------------
   // idle pins: clock parked low, chip select high
   // ----------------------------------------------------------------
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   // ----------------------------------------------------------------
   // one frame: tx words, then nrx reply words while sending idle ones
   // ----------------------------------------------------------------
   // sdo is read half a clock after our rising edge, well before the next fall moves it
   task automatic xfer(input logic [15:0] tx [$], input int nrx, output logic [15:0] rx [$]);
      logic [15:0] w;
      logic [15:0] r;
      rx = {};
      @(posedge clk) cs_n <= 1'b0;
      for (int k = 0; k < tx.size() + nrx; k++) begin
         w = (k < tx.size()) ? tx[k] : IDLE_WORD;
         for (int b = 15; b >= 0; b--) begin
            @(posedge clk);
            sclk <= 1'b0;
            sdi  <= w[b];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            @(negedge clk);
            r[b] = sdo;
            repeat (3) @(posedge clk);
         end
         if (k >= tx.size()) rx.push_back(r);
      end
      @(posedge clk);
      sclk <= 1'b0;
      cs_n <= 1'b1;
      sdi  <= ~sdi;   // released line shows no stale level
      repeat (4) @(posedge clk);
   endtask
endmodule

//--- bench/srrs_cmd_tb_top.sv
// testbench: host command block driven through the modelled host controller
`timescale 1ns/1ps
module srrs_cmd_tb_top;
   import srrs_pkg::*;
   localparam logic [15:0] IDENT = 16'h3c5a;   // arbitrary identification value
   logic        clk, sys_rst, sclk, cs_n, sdi, sdo_o, sdo_oe, fault_n_o, fault_n_oe;
   logic        link_busy_i, safe_hold_enter_i, safe_hold_o;
   logic        link_resync_o, rx_queue_flush_o, link_crc_clear_o, reg_wr_en_i;
   logic [5:0]  reg_wr_addr_i;
   logic [15:0] reg_wr_data_i, iface_status_i, txq_status_i, rxq_status_i;
   logic [15:0] rx [$];
   logic [15:0] dflt [$];
   int          failures, n_compared, n_pulse;
   wire         sdo_line = sdo_oe ? sdo_o : 1'bz;

   srrs_cmd #(.IDENT_CODE(IDENT)) dut_u (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .sdo_o(sdo_o), .sdo_oe(sdo_oe), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
      .link_busy_i(link_busy_i), .safe_hold_enter_i(safe_hold_enter_i), .safe_hold_o(safe_hold_o),
      .link_resync_o(link_resync_o), .rx_queue_flush_o(rx_queue_flush_o), .link_crc_clear_o(link_crc_clear_o),
      .reg_wr_en_i(reg_wr_en_i), .reg_wr_addr_i(reg_wr_addr_i), .reg_wr_data_i(reg_wr_data_i),
      .iface_status_i(iface_status_i), .txq_status_i(txq_status_i), .rxq_status_i(rxq_status_i));
   srrs_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
         failures++;
      end
   endtask
   // bench copy of the host crc, msb first, kept apart from the design's own
   function automatic logic [15:0] crc16(input logic [15:0] init, input logic [15:0] w [$]);
      logic [15:0] c;
      c = init;
      foreach (w[i]) for (int b = 15; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i][b]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr_en_i   <= 1'b1;
      reg_wr_addr_i <= a;
      reg_wr_data_i <= d;
      @(posedge clk);
      reg_wr_en_i   <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // unchecked read; bad flips one crc bit, reply must come regardless
   task automatic rd(input logic [5:0] a, input int n, input logic bad, input logic [15:0] e [$]);
      logic [15:0] cmd;
      cmd = {OP_REG_READ, a, 6'(n - 1)};
      host_u.xfer({cmd, crc16(CRC_INIT_A0, {cmd}) ^ {15'h0, bad}}, n + 1, rx);
      foreach (e[i]) chk(rx[i], e[i]);
      chk(rx[n], crc16(CRC_INIT_A0, e));
   endtask
   task automatic srst(input logic [15:0] c);
      host_u.xfer({CMD_SOFT_RST, c}, 2, rx);
      chk(rx[1], crc16(CRC_INIT_A0, {rx[0]}));
   endtask
   task automatic end_of_test;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog, soft reset pulse monitor
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      end_of_test();
   end
   // the three soft reset strobes must always fire together
   always @(negedge clk) if (link_resync_o | rx_queue_flush_o | link_crc_clear_o) begin
      n_pulse++;
      chk({link_resync_o, rx_queue_flush_o, link_crc_clear_o}, 16'h0007);
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      {link_busy_i, safe_hold_enter_i, reg_wr_en_i, reg_wr_addr_i, reg_wr_data_i} = '0;
      iface_status_i = 16'h0a5a;
      txq_status_i   = 16'h0b6b;
      rxq_status_i   = 16'h0c7c;
      failures = 0;
      n_compared = 0;
      n_pulse = 0;
      dflt = {IDENT, RST_HOST_PORT_CONTROL, RST_LINK_CONTROL, RST_TRANSMIT_QUEUE_LVL, RST_RECEIVE_QUEUE_LVL,
              RST_DEVICE_CONTROL, RST_DIAGNOSTIC_MASK, RST_GLOBAL_STATUS, 16'h0a5a, 16'h0b6b, 16'h0c7c};
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(negedge clk);
      chk({fault_n_o, sdo_oe, fault_n_oe, safe_hold_o}, 16'h0002);
      rd(6'h00, 11, 1'b0, dflt);
      wr(6'h00, 16'h1234);
      wr(6'h07, 16'h0003);
      chk(fault_n_oe, 16'h0000);
      rd(6'h00, 1, 1'b0, {IDENT});
      rd(6'h0b, 1, 1'b0, {16'h0000});
      rd(6'h02, 1, 1'b1, {16'h0000});
      chk(fault_n_oe, 16'h0001);
      rd(6'h07, 1, 1'b0, {16'h0006});
      wr(6'h06, 16'h0006);
      chk(fault_n_oe, 16'h0000);
      // refused while the link transmits, then refused on a bad crc
      wr(6'h07, 16'h0006);
      @(posedge clk) link_busy_i <= 1'b1;
      srst(16'hd383);
      @(posedge clk) link_busy_i <= 1'b0;
      rd(6'h07, 1, 1'b0, {16'h000a});
      wr(6'h07, 16'h000a);
      srst(16'hd384);
      rd(6'h07, 1, 1'b0, {16'h000a});
      chk(16'(n_pulse), 16'h0000);
      // executed soft reset under the alternative crc, out of safe hold
      wr(6'h01, RST_HOST_PORT_CONTROL | 16'h0004);
      wr(6'h02, 16'h0301);
      wr(6'h05, 16'h0055);
      @(posedge clk) safe_hold_enter_i <= 1'b1;
      @(posedge clk) safe_hold_enter_i <= 1'b0;
      @(negedge clk) chk(safe_hold_o, 16'h0001);
      srst(16'hce8c);
      chk(rx[0], RST_GLOBAL_STATUS);
      chk(16'(n_pulse), 16'h0001);
      chk(safe_hold_o, 16'h0000);
      // host flushes the chain with filler words; this block must stay quiet on them
      host_u.xfer({IDLE_WORD, IDLE_WORD}, 1, rx);
      chk(rx[0], IDLE_WORD);
      rd(6'h00, 11, 1'b0, dflt);
      end_of_test();
   end
endmodule
